/* File: src/nfcp_host.sv */
// apb-controlled host that drives a byte-wide nand flash command, address and data port
// Contract
// [R1] each byte is written with write strobe low while chip pick low; captured on rise
// [R2] command latch steers a cycle to commands, address latch to the address path
// [R3] 24 address bits go out in three cycles: column, low row, high row
// [R4] cycle one carries A0-A7, two A9-A16, three A17-A23 with bit 7 don't-care
// [R5] A8 is not sent; read-low and read-high commands select it
// [R6] page read and program commands are followed by all three address cycles
// [R7] all commands take one cycle except erase: setup, block address, execute
// [R8] erase sends only the two row address cycles
// [R9] device decodes data input, confirm, id fetch, spare read, reset, status codes
// [R10] read-low command starts the column within bytes 0 to 255
// [R11] read-high command starts the column within bytes 256 to 511
// [R12] after a high-half access the device returns its pointer to the low half
// [R13] spare read is accepted only while the spare gate is low
// [R14] while busy the device takes only reset and status commands
// [R15] array is 32768 rows of 528 columns; 512 to 527 are spare
// [R16] a 528-byte page register buffers read and program transfers
// [R17] read and program act on pages, erase on blocks
// [R18] each block holds 32 pages; 1024 blocks of 16K bytes
// [R19] the device sequences program and erase internally
// [R20] each data-out pulse falling edge drives the next byte and advances the column
// [R21] ready/busy is low during program, erase or page read
// [R22] chip pick high ends a read; ignored during busy program or erase
// [R23] other commands while busy are ignored
`timescale 1ns/10ps
`include "nfcp_regs.svh"
module nfcp_host (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_reg,
  output logic             pready_reg,
  output logic             pslverr_reg,
  // nand bus
  input  wire logic [7:0]  io_in,
  output logic [7:0]       io_out_reg,
  output logic             io_oe_reg,
  output logic             cmd_latch_reg,
  output logic             addr_latch_reg,
  output logic             chip_pick_n_reg,
  output logic             write_strobe_n_reg,
  output logic             data_out_pulse_n_reg,
  output logic             spare_area_gate_n_reg,
  output logic             write_protect_n_reg,
  input  wire logic        ready_busy_n
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] io_s1_reg, io_s2_reg;
  logic       rb_s1_reg, rb_s2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else begin
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= ready_busy_n;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {Q_IDLE, Q_CMD, Q_ADDR, Q_DATA} nfcp_qst_t;
  nfcp_qst_t               q_reg, q_next;
  nfcp_pkg::nfcp_op_t      op_reg, op_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0]  wd_reg, wd_next;
  logic [7:0]  rd_reg, rd_next;
  logic [1:0]  acnt_reg, acnt_next;
  logic        go_reg, go_next;
  logic        done_flag_reg, done_flag_next;
  logic        rv_reg, rv_next;
  logic        spare_reg, spare_next;
  logic        wp_reg, wp_next;
  logic        ce_next;
  logic [31:0] prd_next;
  logic        rdy_next, err_next;
  logic        s_start;
  nfcp_pkg::nfcp_cyc_t s_kind;
  logic [7:0]  s_byte;
  logic        s_done;
  logic [7:0]  s_rbyte;

  function automatic logic [7:0] addr_byte(input logic [23:0] a, input logic [1:0] idx);
    case (idx)
      2'd0:    addr_byte = a[7:0];                 // R4
      2'd1:    addr_byte = a[16:9];                // R4
      default: addr_byte = {1'b0, a[23:17]};       // R4
    endcase
  endfunction : addr_byte

  wire acc = psel && penable;
  wire wr  = acc && pwrite && !pready_reg;
  wire rdq = acc && !pwrite && !pready_reg;

  always_comb begin
    q_next = q_reg;
    op_next = op_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    acnt_next = acnt_reg;
    go_next = go_reg;
    done_flag_next = done_flag_reg;
    rv_next = rv_reg;
    spare_next = spare_reg;
    wp_next = wp_reg;
    ce_next = chip_pick_n_reg;
    prd_next = prdata_reg;
    rdy_next = 1'b0;
    err_next = 1'b0;
    s_start = 1'b0;
    s_kind = nfcp_pkg::NFCP_CYC_CMD;
    s_byte = cmd_reg;
    // apb register access, one wait state
    if (wr || rdq) begin
      rdy_next = 1'b1;
      prd_next = 32'h0000_0000;
      case (paddr)
        `NFCP_CTRL_OFF: begin
          if (wr && !go_reg) begin
            cmd_next = pwdata[`NFCP_CTRL_CMD_LSB +: 8];
            op_next = nfcp_pkg::nfcp_op_t'(pwdata[`NFCP_CTRL_OP_LSB +: 3]);
            go_next = pwdata[`NFCP_CTRL_GO_BIT];
            if (pwdata[`NFCP_CTRL_GO_BIT]) begin
              done_flag_next = 1'b0;
            end
          end
          prd_next = {20'h0_0000, go_reg, 3'(op_reg), cmd_reg};
        end
        `NFCP_ADDR_OFF: begin
          if (wr) addr_next = pwdata[23:0];        // R3
          prd_next = {8'h00, addr_reg};
        end
        `NFCP_WDATA_OFF: begin
          if (wr) wd_next = pwdata[7:0];
          prd_next = {24'h00_0000, wd_reg};
        end
        `NFCP_RDATA_OFF: begin
          prd_next = {24'h00_0000, rd_reg};
          if (rdq) rv_next = 1'b0;
        end
        `NFCP_STAT_OFF: begin
          prd_next = {28'h000_0000, rv_reg, done_flag_reg, rb_s2_reg, go_reg}; // R21
          if (rdq) done_flag_next = 1'b0;
        end
        `NFCP_CFG_OFF: begin
          if (wr) begin
            spare_next = pwdata[`NFCP_CFG_SPARE_BIT]; // R13
            wp_next = pwdata[`NFCP_CFG_WP_BIT];
          end
          prd_next = {30'h0000_0000, wp_reg, spare_reg};
        end
        default: err_next = 1'b1;
      endcase
    end
    // bus sequencing
    case (q_reg)
      Q_IDLE: begin
        if (go_reg) begin
          ce_next = 1'b0;                          // R1
          case (op_reg)
            nfcp_pkg::NFCP_OP_ADDR1: begin
              acnt_next = 2'd0;
              q_next = Q_ADDR;
            end
            nfcp_pkg::NFCP_OP_WDATA, nfcp_pkg::NFCP_OP_RDATA: q_next = Q_DATA;
            default: q_next = Q_CMD;
          endcase
        end
      end
      Q_CMD: begin
        s_start = 1'b1;                            // R7
        s_kind = nfcp_pkg::NFCP_CYC_CMD;
        s_byte = cmd_reg;
        if (s_done) begin
          // erase skips the column cycle
          acnt_next = (op_reg == nfcp_pkg::NFCP_OP_CMD_ADDR2) ? 2'd1 : 2'd0; // R8
          if (op_reg == nfcp_pkg::NFCP_OP_CMD_ADDR3 || op_reg == nfcp_pkg::NFCP_OP_CMD_ADDR2) begin
            q_next = Q_ADDR;                       // R6
          end else begin
            go_next = 1'b0;
            done_flag_next = 1'b1;
            q_next = Q_IDLE;
          end
        end
      end
      Q_ADDR: begin
        s_start = 1'b1;
        s_kind = nfcp_pkg::NFCP_CYC_ADDR;
        s_byte = addr_byte(addr_reg, acnt_reg);    // R3
        if (s_done) begin
          acnt_next = acnt_reg + 2'd1;
          if (acnt_reg == 2'd2 || op_reg == nfcp_pkg::NFCP_OP_ADDR1) begin
            go_next = 1'b0;
            done_flag_next = 1'b1;
            q_next = Q_IDLE;
          end
        end
      end
      Q_DATA: begin
        s_start = 1'b1;
        s_kind = (op_reg == nfcp_pkg::NFCP_OP_RDATA) ? nfcp_pkg::NFCP_CYC_RDATA
                                                      : nfcp_pkg::NFCP_CYC_WDATA;
        s_byte = wd_reg;
        if (s_done) begin
          if (op_reg == nfcp_pkg::NFCP_OP_RDATA) begin
            rd_next = s_rbyte;                     // R20
            rv_next = 1'b1;
          end
          go_next = 1'b0;
          done_flag_next = 1'b1;
          q_next = Q_IDLE;
        end
      end
      default: q_next = Q_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= Q_IDLE;
      op_reg <= nfcp_pkg::NFCP_OP_CMD;
      cmd_reg <= `NFCP_CMD_STATUS;
      addr_reg <= 24'h00_0000;
      wd_reg <= 8'h00;
      rd_reg <= 8'h00;
      acnt_reg <= 2'd0;
      go_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      rv_reg <= 1'b0;
      spare_reg <= 1'(`NFCP_CFG_RESET >> `NFCP_CFG_SPARE_BIT);
      wp_reg <= 1'(`NFCP_CFG_RESET >> `NFCP_CFG_WP_BIT);
      chip_pick_n_reg <= 1'b1;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      op_reg <= op_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      acnt_reg <= acnt_next;
      go_reg <= go_next;
      done_flag_reg <= done_flag_next;
      rv_reg <= rv_next;
      spare_reg <= spare_next;
      wp_reg <= wp_next;
      chip_pick_n_reg <= ce_next;
      prdata_reg <= prd_next;
      pready_reg <= rdy_next;
      pslverr_reg <= err_next;
    end
  end

  // spare gate pin is active low: cfg bit 0 set means spare area enabled (gate low)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spare_area_gate_n_reg <= 1'b0;
      write_protect_n_reg <= 1'b1;
    end else begin
      spare_area_gate_n_reg <= !spare_reg;          // R13
      write_protect_n_reg <= wp_reg;
    end
  end

  nfcp_strobe u_strobe (
    .pclk                 (pclk),
    .presetn              (presetn),
    .start                (s_start && !s_done),
    .kind                 (s_kind),
    .wbyte                (s_byte),
    .done_reg             (s_done),
    .rbyte_reg            (s_rbyte),
    .io_in_sync           (io_s2_reg),
    .io_out_reg           (io_out_reg),
    .io_oe_reg            (io_oe_reg),
    .cmd_latch_reg        (cmd_latch_reg),
    .addr_latch_reg       (addr_latch_reg),
    .write_strobe_n_reg   (write_strobe_n_reg),
    .data_out_pulse_n_reg (data_out_pulse_n_reg)
  );
endmodule : nfcp_host

/* File: src/nfcp_pkg.sv */
// types of the nand host port
package nfcp_pkg;
  typedef enum logic [2:0] {
    NFCP_OP_CMD,
    NFCP_OP_CMD_ADDR3,
    NFCP_OP_CMD_ADDR2,
    NFCP_OP_ADDR1,
    NFCP_OP_WDATA,
    NFCP_OP_RDATA
  } nfcp_op_t;
  typedef enum logic [1:0] {
    NFCP_CYC_CMD,
    NFCP_CYC_ADDR,
    NFCP_CYC_WDATA,
    NFCP_CYC_RDATA
  } nfcp_cyc_t;
endpackage : nfcp_pkg

/* File: src/nfcp_regs.svh */
// register offsets, field positions, command codes and pin timing counts for the nand host port
`ifndef NFCP_REGS_SVH
`define NFCP_REGS_SVH
// ----------------------------------------
// apb register offsets
// ----------------------------------------
`define NFCP_CTRL_OFF      12'h000
`define NFCP_ADDR_OFF      12'h004
`define NFCP_WDATA_OFF     12'h008
`define NFCP_RDATA_OFF     12'h00C
`define NFCP_STAT_OFF      12'h010
`define NFCP_CFG_OFF       12'h014
// ----------------------------------------
// ctrl fields: [7:0] command code, [10:8] operation, [11] start
// ----------------------------------------
`define NFCP_CTRL_CMD_LSB  0
`define NFCP_CTRL_OP_LSB   8
`define NFCP_CTRL_GO_BIT   11
// ----------------------------------------
// status fields
// ----------------------------------------
`define NFCP_STAT_BUSY_BIT 0
`define NFCP_STAT_RB_BIT   1
`define NFCP_STAT_DONE_BIT 2
`define NFCP_STAT_RV_BIT   3
// ----------------------------------------
// cfg fields and reset values
// ----------------------------------------
`define NFCP_CFG_SPARE_BIT 0
`define NFCP_CFG_WP_BIT    1
`define NFCP_CFG_RESET     32'h0000_0003
// ----------------------------------------
// command codes
// ----------------------------------------
`define NFCP_CMD_READ_LO   8'h00
`define NFCP_CMD_READ_HI   8'h01
`define NFCP_CMD_PROG_CONF 8'h10
`define NFCP_CMD_SPARE_RD  8'h50
`define NFCP_CMD_ERASE_SET 8'h60
`define NFCP_CMD_STATUS    8'h70
`define NFCP_CMD_SEQ_IN    8'h80
`define NFCP_CMD_ID_FETCH  8'h90
`define NFCP_CMD_ERASE_GO  8'hD0
`define NFCP_CMD_RESET     8'hFF
// ----------------------------------------
// pin phase length: strobe low and high each take this many pclk cycles
// ----------------------------------------
`define NFCP_T_PHASE_NS    30
`define NFCP_PHASE_CYC     ((`NFCP_T_PHASE_NS + 9) / 10)
`define NFCP_PAGE_BYTES    528
`define NFCP_ROWS          32768
`endif

/* File: src/nfcp_strobe.sv */
// one nand bus cycle: drives latch strobes, write or read strobe, captures read byte
`timescale 1ns/10ps
`include "nfcp_regs.svh"
module nfcp_strobe (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // request
  input  wire logic             start,
  input  wire nfcp_pkg::nfcp_cyc_t kind,
  input  wire logic [7:0]       wbyte,
  output logic                  done_reg,
  output logic [7:0]            rbyte_reg,
  // pins
  input  wire logic [7:0]       io_in_sync,
  output logic [7:0]            io_out_reg,
  output logic                  io_oe_reg,
  output logic                  cmd_latch_reg,
  output logic                  addr_latch_reg,
  output logic                  write_strobe_n_reg,
  output logic                  data_out_pulse_n_reg
);
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} nfcp_sst_t;
  nfcp_sst_t   st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        rd_reg, rd_next;
  logic [7:0]  io_next, rb_next;
  logic        oe_next, cl_next, al_next, we_next, dp_next, dn_next;
  localparam logic [3:0] PH = 4'(`NFCP_PHASE_CYC);

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    io_next = io_out_reg;
    rb_next = rbyte_reg;
    oe_next = io_oe_reg;
    cl_next = cmd_latch_reg;
    al_next = addr_latch_reg;
    we_next = write_strobe_n_reg;
    dp_next = data_out_pulse_n_reg;
    dn_next = 1'b0;
    case (st_reg)
      S_IDLE: begin
        if (start) begin
          rd_next = (kind == nfcp_pkg::NFCP_CYC_RDATA);
          cl_next = (kind == nfcp_pkg::NFCP_CYC_CMD); // R2
          al_next = (kind == nfcp_pkg::NFCP_CYC_ADDR); // R2
          oe_next = !rd_next;
          io_next = wbyte;
          we_next = rd_next;                          // R1
          dp_next = !rd_next;                         // R20
          cnt_next = PH;
          st_next = S_LOW;
        end
      end
      S_LOW: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          if (rd_reg) begin
            rb_next = io_in_sync;
          end
          we_next = 1'b1;                             // R1
          dp_next = 1'b1;
          cnt_next = PH;
          st_next = S_HIGH;
        end
      end
      S_HIGH: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          cl_next = 1'b0;
          al_next = 1'b0;
          oe_next = 1'b0;
          dn_next = 1'b1;
          st_next = S_IDLE;
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      io_out_reg <= 8'h00;
      rbyte_reg <= 8'h00;
      io_oe_reg <= 1'b0;
      cmd_latch_reg <= 1'b0;
      addr_latch_reg <= 1'b0;
      write_strobe_n_reg <= 1'b1;
      data_out_pulse_n_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      io_out_reg <= io_next;
      rbyte_reg <= rb_next;
      io_oe_reg <= oe_next;
      cmd_latch_reg <= cl_next;
      addr_latch_reg <= al_next;
      write_strobe_n_reg <= we_next;
      data_out_pulse_n_reg <= dp_next;
      done_reg <= dn_next;
    end
  end
endmodule : nfcp_strobe

/* File: testbench/nfcp_host_asserts.sv */
// pin and apb checker for the nand host port
`timescale 1ns/10ps
module nfcp_host_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready_reg,
  input wire logic       pslverr_reg,
  // nand bus
  input wire logic [7:0] io_out_reg,
  input wire logic       io_oe_reg,
  input wire logic       cmd_latch_reg,
  input wire logic       addr_latch_reg,
  input wire logic       chip_pick_n_reg,
  input wire logic       write_strobe_n_reg,
  input wire logic       data_out_pulse_n_reg,
  input wire logic       spare_area_gate_n_reg
);
  logic       we_q_reg, we_q_next;
  logic [7:0] last_cmd_reg, last_cmd_next;
  logic [2:0] acnt_reg, acnt_next;
  logic       stb;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // address cycles since the last command
  // ----
  assign stb = we_q_reg && !write_strobe_n_reg;
  always_comb begin
    we_q_next = write_strobe_n_reg;
    last_cmd_next = last_cmd_reg;
    acnt_next = acnt_reg;
    if (stb && cmd_latch_reg) begin
      last_cmd_next = io_out_reg;
      acnt_next = 3'h0;
    end else if (stb && addr_latch_reg && acnt_reg != 3'h7) begin
      acnt_next = acnt_reg + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_q_reg <= 1'b1;
      last_cmd_reg <= 8'hFF;
      acnt_reg <= 3'h0;
    end else begin
      we_q_reg <= we_q_next;
      last_cmd_reg <= last_cmd_next;
      acnt_reg <= acnt_next;
    end
  end
  a_apb_one_wait: assert property (psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("apb answer is not one pulse one cycle after access");
  a_err_with_ready: assert property (pslverr_reg |-> pready_reg)
    else $error("error response without ready");
  a_strobe_chip_pick: assert property (!write_strobe_n_reg |-> !chip_pick_n_reg)
    else $error("write strobe low while chip deselected");
  a_latch_exclusive: assert property (!(cmd_latch_reg && addr_latch_reg))
    else $error("both latch strobes high");
  a_strobe_low_len: assert property ($fell(write_strobe_n_reg) |->
    !write_strobe_n_reg [*3] ##1 write_strobe_n_reg) else $error("write strobe low length wrong");
  a_byte_held: assert property ($fell(write_strobe_n_reg) |-> io_oe_reg ##1 (io_oe_reg &&
    $stable(io_out_reg) && $stable(cmd_latch_reg) && $stable(addr_latch_reg)) [*3])
    else $error("byte or latches moved around write strobe");
  a_read_quiet: assert property (!data_out_pulse_n_reg |-> !io_oe_reg &&
    write_strobe_n_reg && !cmd_latch_reg && !addr_latch_reg) else $error("host drives during read");
  a_spare_gate: assert property (stb && cmd_latch_reg && io_out_reg == 8'h50 |->
    !spare_area_gate_n_reg) else $error("spare read issued with gate high");
  a_page_addr_three: assert property (stb && cmd_latch_reg &&
    last_cmd_reg inside {8'h00, 8'h01, 8'h50, 8'h80} |-> acnt_reg == 3'h3)
    else $error("page command not followed by three address cycles");
  a_erase_two_rows: assert property (stb && cmd_latch_reg && last_cmd_reg == 8'h60 |->
    acnt_reg == 3'h2 && io_out_reg == 8'hD0) else $error("erase setup not two rows then execute");
endmodule : nfcp_host_asserts
bind nfcp_host nfcp_host_asserts i_nfcp_host_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
  .io_out_reg(io_out_reg), .io_oe_reg(io_oe_reg), .cmd_latch_reg(cmd_latch_reg),
  .addr_latch_reg(addr_latch_reg), .chip_pick_n_reg(chip_pick_n_reg),
  .write_strobe_n_reg(write_strobe_n_reg), .data_out_pulse_n_reg(data_out_pulse_n_reg),
  .spare_area_gate_n_reg(spare_area_gate_n_reg));

/* File: testbench/nfcp_host_tb_top.sv */
// self-checking bench for the apb nand host port
`timescale 1ns/10ps
`include "nfcp_regs.svh"
module nfcp_host_tb_top;
  logic        pclk = 1'b0, presetn, psel, penable, pwrite, pready_reg, pslverr_reg, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_reg, rd;
  logic [7:0]  io_in, io_out_reg, dq;
  logic        io_oe_reg, cmd_latch_reg, addr_latch_reg, chip_pick_n_reg, write_strobe_n_reg;
  logic        data_out_pulse_n_reg, spare_area_gate_n_reg, write_protect_n_reg, dq_oe, rb_n;
  int          err_count, cmp_count;
  nfcp_host i_nfcp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg),
    .pready_reg(pready_reg), .pslverr_reg(pslverr_reg), .io_in(io_in), .io_out_reg(io_out_reg),
    .io_oe_reg(io_oe_reg), .cmd_latch_reg(cmd_latch_reg), .addr_latch_reg(addr_latch_reg),
    .chip_pick_n_reg(chip_pick_n_reg), .write_strobe_n_reg(write_strobe_n_reg),
    .data_out_pulse_n_reg(data_out_pulse_n_reg), .spare_area_gate_n_reg(spare_area_gate_n_reg),
    .write_protect_n_reg(write_protect_n_reg), .ready_busy_n(rb_n));
  nfcp_nand_model i_nfcp_nand_model (.io(io_out_reg), .cle(cmd_latch_reg),
    .ale(addr_latch_reg), .ce_n(chip_pick_n_reg), .we_n(write_strobe_n_reg),
    .data_out_pulse_n(data_out_pulse_n_reg), .spare_area_gate_n(spare_area_gate_n_reg),
    .wp_n(write_protect_n_reg), .dq(dq), .dq_oe(dq_oe), .rb_n(rb_n));
  // released bus shows the inverse, not a stale byte
  assign io_in = io_oe_reg ? io_out_reg : dq_oe ? dq : ~io_out_reg;
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_reg !== 1'b1) @(posedge pclk);
    rd = prdata_reg;
    err = pslverr_reg;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic go(input logic [2:0] op, input logic [7:0] code);
    apb(1'b1, `NFCP_CTRL_OFF, {20'h0_0000, 1'b1, op, code});
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0) apb(1'b0, `NFCP_STAT_OFF, 32'h0000_0000);
  endtask : go
  task automatic wait_ready;
    rd = 32'h0000_0000;
    while (rd[1] !== 1'b1) apb(1'b0, `NFCP_STAT_OFF, 32'h0000_0000);
  endtask : wait_ready
  task automatic page(input logic [7:0] code, input int row, input int col);
    apb(1'b1, `NFCP_ADDR_OFF, 32'(row * 512 + col));
    go(3'h1, code);
    wait_ready();
  endtask : page
  task automatic rd_byte(input logic [7:0] e);
    go(3'h5, 8'h00);
    apb(1'b0, `NFCP_RDATA_OFF, 32'h0000_0000);
    chk(rd, {24'h00_0000, e});
  endtask : rd_byte
  task automatic t_regs;
    apb(1'b0, `NFCP_CFG_OFF, 32'h0000_0000);
    chk(rd, `NFCP_CFG_RESET);
    apb(1'b1, `NFCP_CFG_OFF, 32'h0000_0000);
    apb(1'b0, `NFCP_CFG_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({30'h0000_0000, spare_area_gate_n_reg, write_protect_n_reg}, 32'h0000_0002);
    apb(1'b1, `NFCP_CFG_OFF, `NFCP_CFG_RESET);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_program;
    page(8'h80, 12, 4);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `NFCP_WDATA_OFF, 32'(8'h3C + i));
      go(3'h4, 8'h00);
    end
    go(3'h0, 8'h10);
    wait_ready();
    for (int i = 0; i < 4; i++) chk(i_nfcp_nand_model.mem[12 * 528 + 4 + i], 32'(8'h3C + i));
    $display("t_program done");
  endtask : t_program
  task automatic t_read;
    page(8'h00, 12, 4);
    for (int i = 0; i < 4; i++) rd_byte(8'(8'h3C + i));
    page(8'h01, 40, 4);
    rd_byte(i_nfcp_nand_model.pat(40, 260));
    rd_byte(i_nfcp_nand_model.pat(40, 261));
    page(8'h50, 40, 3);
    rd_byte(i_nfcp_nand_model.pat(40, 515));
    // column 5, row 1285 sent one address byte at a time
    apb(1'b1, `NFCP_ADDR_OFF, 32'h000A_0A05);
    go(3'h0, 8'h00);
    for (int i = 0; i < 3; i++) go(3'h3, 8'h00);
    wait_ready();
    rd_byte(i_nfcp_nand_model.pat(1285, 5));
    go(3'h0, 8'h90);
    rd_byte(i_nfcp_nand_model.ID_BYTE);
    $display("t_read done");
  endtask : t_read
  task automatic t_erase;
    apb(1'b1, `NFCP_ADDR_OFF, 32'(12 * 512));
    go(3'h2, 8'h60);
    go(3'h0, 8'hD0);
    go(3'h0, 8'h70);
    rd_byte(8'h80);
    go(3'h0, 8'h90);
    rd_byte(8'h80);
    wait_ready();
    rd_byte(8'hC0);
    page(8'h00, 12, 4);
    rd_byte(8'hFF);
    page(8'h00, 32, 0);
    rd_byte(i_nfcp_nand_model.pat(32, 0));
    $display("t_erase done");
  endtask : t_erase
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_program();
    t_read();
    t_erase();
    end_of_test();
  end
  // eight busy periods of 200 cycles plus polling stay far below this
  initial begin
    #400_000;
    err_count++;
    end_of_test();
  end
endmodule : nfcp_host_tb_top

/* File: testbench/nfcp_nand_model.sv */
// behavioural byte-wide nand device facing the host port
`timescale 1ns/10ps
module nfcp_nand_model #(
  parameter int         BUSY_NS = 2000,
  parameter logic [7:0] ID_BYTE = 8'hA5  // arbitrary value
) (
  // host driven pins
  input wire logic [7:0] io,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       ce_n,
  input wire logic       we_n,
  input wire logic       data_out_pulse_n,
  input wire logic       spare_area_gate_n,
  input wire logic       wp_n,
  // device driven pins
  output logic [7:0]     dq,
  output logic           dq_oe,
  output logic           rb_n
);
  logic [7:0] mem [int];  // untouched bytes read as pat()
  logic [7:0] pg [528];
  logic [7:0] cmd = 8'hFF;
  logic [7:0] ab [3];
  logic       half = 1'b0;
  int         na = 0, col = 0, row = 0, i;
  initial dq = 8'h00;
  initial dq_oe = 1'b0;
  initial rb_n = 1'b1;
  function automatic logic [7:0] pat(input int r, input int c);
    return 8'(r * 7 + c);
  endfunction : pat
  task automatic busy;
    rb_n = 1'b0;
    rb_n <= #BUSY_NS 1'b1;
  endtask : busy
  always @(posedge we_n) begin
    if (!ce_n && cle && (rb_n || io == 8'hFF || io == 8'h70) &&
        !(io == 8'h50 && spare_area_gate_n)) begin
      cmd = io;
      na = 0;
      if (io == 8'h00 || io == 8'h01) half = io[0];
      if (io == 8'h80) pg = '{default: 8'hFF};
      if (io == 8'h10 && wp_n) begin
        for (i = 0; i < 528; i++) mem[row * 528 + i] = pg[i];
        busy();
      end
      if (io == 8'hD0 && wp_n) begin
        for (i = 0; i < 32 * 528; i++) mem[(row / 32) * 32 * 528 + i] = 8'hFF;
        busy();
      end
      if (io == 8'hFF) rb_n <= #20 1'b1;
    end else if (!ce_n && ale && rb_n && na < 3) begin
      ab[na] = io;
      na++;
      if (cmd == 8'h60 && na == 2) row = {ab[1][6:0], ab[0]};
      if (cmd != 8'h60 && na == 3) begin
        row = {ab[2][6:0], ab[1]};
        col = cmd == 8'h50 ? 512 + ab[0][3:0] : ab[0] + (half ? 256 : 0);
        half = 1'b0;
        if (cmd != 8'h80) begin
          for (i = 0; i < 528; i++) pg[i] = mem.exists(row * 528 + i) ? mem[row * 528 + i] : pat(row, i);
          busy();
        end
      end
    end else if (!ce_n && !cle && !ale && rb_n && col < 528) begin
      pg[col] = io;
      col++;
    end
  end
  always @(negedge data_out_pulse_n) begin
    if (!ce_n) begin
      dq_oe = 1'b1;
      dq = cmd == 8'h70 ? {1'b1, rb_n, 6'h00} : cmd == 8'h90 ? ID_BYTE : pg[col % 528];
      col++;
    end
  end
  always @(posedge data_out_pulse_n or posedge ce_n) dq_oe = 1'b0;
endmodule : nfcp_nand_model
